// ==== burst_trigger_sequencer.sv ====
// Trigger qualification and burst exposure sequencer with Avalon-MM registers
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Burst style off, repeat one, alternate two
// - Repeat: shutter time, or pulse width
// - Edge alternate: first then second shutter
// - Width alternate: width then width times multiplier
// - Count limited: exactly burst length exposures
// - While asserted: repeat while trigger active
// - While asserted only under edge timing
// - Burst length 0..65533, reset 1, 0 endless
// - Abort command ends repeated exposures
// - Second shutter 1..6000000 us, reset 83998
// - Multiplier only 1, 2, 4, 8, 16
// - While asserted ends on release or count
// - Block set ignores all triggers
// - Trigger lag 0..4000000 us, reset 0
// - Count only accepted triggers
// - Counter wraps to 0 at top
// - Clear command zeroes counter
// - Filter drops pulses shorter than minimum
// - Filter off at reset, min 1..2000000
// - Filtered exposure starts after minimum width
// - No exposure for rejected pulses
// - Shutter source: edge timed or pulse width
// - Origin: line one, line two, software
module burst_trigger_sequencer
	import burst_trigger_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trig_line1,
	input wire logic trig_line2,
	output logic exposure,
	output logic second_exposure
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sync1; // First synchroniser stage
		logic [1:0] sync2; // Second synchroniser stage
		logic trig_prev; // Trigger level last cycle
		logic [6:0] div; // Tick divider
		logic tick; // One microsecond pulse
		logic ack; // Bus answer cycle
		logic [31:0] rdata; // Read data
		logic [1:0] style;
		logic policy;
		logic source;
		logic [2:0] origin;
		logic block;
		logic filter;
		logic [4:0] mult;
		logic [15:0] burst_length;
		logic [22:0] shutter_us;
		logic [22:0] second_shutter_us;
		logic [22:0] lag_us;
		logic [22:0] filter_min_us;
		logic [30:0] count; // Accepted triggers
		seq_state_t st;
		logic [27:0] timer; // Microsecond timer
		logic [27:0] width; // Measured pulse width
		logic [15:0] done; // Exposures finished
		logic phase; // 1 while second exposure
		logic expo; // Exposure output
		logic sec; // Second exposure output
	} state_t;

	state_t r;
	state_t next_r;

	logic trig_now; // Selected trigger level
	logic trig_rise; // Active edge
	logic bus_wr; // Write accepted this cycle
	logic abort_cmd;
	logic clear_cmd;
	logic soft_cmd;
	logic accept; // Trigger accepted
	logic last_exp; // Burst has finished its count
	logic [27:0] exp_len; // Length of the coming exposure
	logic [3:0] word; // Register word index

	// ----------------------------------------------------------------
	// Bus decode and commands
	// ----------------------------------------------------------------
	// One wait state on every access, commands are write-1 pulses
	assign word = avs_address[5:2];
	assign bus_wr = avs_write && r.ack && avs_byteenable == 4'hf;
	assign abort_cmd = bus_wr && word == reg_control && avs_writedata[ctl_abort];
	assign clear_cmd = bus_wr && word == reg_control && avs_writedata[ctl_clear];
	assign soft_cmd = bus_wr && word == reg_control && avs_writedata[ctl_soft];
	assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
	assign avs_readdata = r.rdata;
	assign exposure = r.expo;
	assign second_exposure = r.sec;

	// ----------------------------------------------------------------
	// Trigger path
	// ----------------------------------------------------------------
	// Origin selector; software pulse behaves as a one cycle trigger
	always_comb begin
		unique case (r.origin)
			origin_line1: trig_now = r.sync2[0];
			origin_line2: trig_now = r.sync2[1];
			origin_soft: trig_now = soft_cmd;
			default: trig_now = 1'b0;
		endcase
	end
	// A blocked trigger never forms an edge
	assign trig_rise = trig_now && !r.trig_prev && !r.block;

	// Count of exposures reached (0 means endless)
	assign last_exp = r.burst_length != 16'h0000 && r.done + 16'h0001 >= r.burst_length;

	// Length of the next exposure in microseconds
	always_comb begin
		if (r.source == pulse_width_timed) begin
			if (r.phase && r.style == two_time_alternate)
				exp_len = 28'(r.width * r.mult);
			else
				exp_len = r.width;
		end else begin
			exp_len = (r.phase && r.style == two_time_alternate) ?
				28'(r.second_shutter_us) : 28'(r.shutter_us);
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		accept = 1'b0;
		// Two flop synchronisers for the external lines
		next_r.sync1 = {trig_line2, trig_line1};
		next_r.sync2 = r.sync1;
		next_r.trig_prev = trig_now;
		// Microsecond divider
		next_r.tick = (r.div == tick_last);
		next_r.div = (r.div == tick_last) ? 7'h00 : r.div + 7'h01;
		// Bus: one wait cycle, then answer
		next_r.ack = (avs_read || avs_write) && !r.ack;
		if (avs_read && !r.ack) begin
			unique case (word)
				reg_control: next_r.rdata = 32'({r.mult, r.filter, r.block, r.origin,
					r.source, r.policy, r.style});
				reg_burst_length: next_r.rdata = 32'(r.burst_length);
				reg_shutter_us: next_r.rdata = 32'(r.shutter_us);
				reg_second_shutter_us: next_r.rdata = 32'(r.second_shutter_us);
				reg_trig_lag_us: next_r.rdata = 32'(r.lag_us);
				reg_width_filter_min_us: next_r.rdata = 32'(r.filter_min_us);
				reg_accepted_count: next_r.rdata = 32'(r.count);
				reg_status: next_r.rdata = 32'({r.done, 5'h00, r.phase, r.expo, r.st});
				default: next_r.rdata = 32'h00000000;
			endcase
		end
		// Register writes, out of range values keep the old setting
		if (bus_wr) begin
			unique case (word)
				reg_control: begin
					if (avs_writedata[ctl_style_lo +: 2] <= two_time_alternate)
						next_r.style = avs_writedata[ctl_style_lo +: 2];
					next_r.policy = avs_writedata[ctl_policy];
					next_r.source = avs_writedata[ctl_source];
					if (avs_writedata[ctl_origin_lo +: 3] inside {origin_line1, origin_line2,
						origin_soft})
						next_r.origin = avs_writedata[ctl_origin_lo +: 3];
					next_r.block = avs_writedata[ctl_block];
					next_r.filter = avs_writedata[ctl_filter];
					if (avs_writedata[ctl_mult_lo +: 5] inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
						next_r.mult = avs_writedata[ctl_mult_lo +: 5];
				end
				reg_burst_length:
					if (avs_writedata <= 32'(burst_length_max))
						next_r.burst_length = avs_writedata[15:0];
				reg_shutter_us:
					if (avs_writedata >= 32'(shutter_min) && avs_writedata <= 32'(shutter_max))
						next_r.shutter_us = avs_writedata[22:0];
				reg_second_shutter_us:
					if (avs_writedata >= 32'(shutter_min) && avs_writedata <= 32'(shutter_max))
						next_r.second_shutter_us = avs_writedata[22:0];
				reg_trig_lag_us:
					if (avs_writedata <= 32'(lag_max))
						next_r.lag_us = avs_writedata[22:0];
				reg_width_filter_min_us:
					if (avs_writedata >= 32'(shutter_min) && avs_writedata <= 32'(filter_min_max))
						next_r.filter_min_us = avs_writedata[22:0];
				default: ;
			endcase
		end
		// Sequencer
		unique case (r.st)
			st_idle: begin
				next_r.done = 16'h0000;
				next_r.phase = 1'b0;
				next_r.timer = 28'h0000000;
				next_r.width = 28'h0000000;
				if (trig_rise) begin
					if (r.filter)
						next_r.st = st_qualify;
					else begin
						accept = 1'b1;
						next_r.st = st_lag;
					end
				end
			end
			// Pulse must stay active for the minimum width
			st_qualify: begin
				if (!trig_now)
					next_r.st = st_idle;
				else if (r.tick) begin
					next_r.timer = r.timer + 28'h0000001;
					next_r.width = r.width + 28'h0000001;
					if (r.timer + 28'h0000001 >= 28'(r.filter_min_us)) begin
						accept = 1'b1;
						next_r.timer = 28'h0000000;
						next_r.st = st_lag;
					end
				end
			end
			st_lag: begin
				if (r.source == pulse_width_timed && r.tick && trig_now)
					next_r.width = r.width + 28'h0000001;
				if (r.timer >= 28'(r.lag_us)) begin
					next_r.timer = 28'h0000000;
					next_r.st = (r.source == pulse_width_timed) ? st_measure : st_expose;
					next_r.expo = 1'b1;
				end else if (r.tick)
					next_r.timer = r.timer + 28'h0000001;
			end
			// Width timed first exposure follows the trigger level
			st_measure: begin
				if (!trig_now) begin
					next_r.expo = 1'b0;
					next_r.timer = 28'h0000000;
					if (r.style == style_off || last_exp)
						next_r.st = st_idle;
					else begin
						next_r.done = r.done + 16'h0001;
						next_r.phase = (r.style == two_time_alternate);
						next_r.st = st_gap;
					end
				end else if (r.tick)
					next_r.width = r.width + 28'h0000001;
			end
			st_expose: begin
				if (r.tick)
					next_r.timer = r.timer + 28'h0000001;
				if (r.tick && r.timer + 28'h0000001 >= exp_len) begin
					next_r.expo = 1'b0;
					next_r.timer = 28'h0000000;
					if (r.style == style_off || last_exp)
						next_r.st = st_idle;
					else if (r.policy == while_asserted && r.source == edge_timed && !trig_now)
						next_r.st = st_idle;
					else begin
						next_r.done = r.done + 16'h0001;
						if (r.style == two_time_alternate)
							next_r.phase = !r.phase;
						next_r.st = st_gap;
					end
				end
			end
			// One cycle between exposures of a burst
			st_gap: begin
				next_r.expo = 1'b1;
				next_r.st = st_expose;
			end
			default: next_r.st = st_idle;
		endcase
		if (abort_cmd && r.st != st_idle && r.st != st_qualify) begin
			next_r.st = st_idle;
			next_r.expo = 1'b0;
		end
		// Accepted trigger counter; count wins over a clear
		if (accept)
			next_r.count = (r.count == count_top) ? 31'h00000000 : r.count + 31'h00000001;
		else if (clear_cmd)
			next_r.count = 31'h00000000;
		// Second exposure flag registered together with the exposure
		next_r.sec = next_r.expo && next_r.phase;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset: settings take their defaults, all else clears
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r <= '0;
			r.st <= st_idle;
			r.burst_length <= burst_length_rst;
			r.shutter_us <= shutter_rst;
			r.second_shutter_us <= second_shutter_rst;
			r.lag_us <= lag_rst;
			r.filter_min_us <= filter_min_rst;
			r.mult <= mult_rst;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	block_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.block && r.st == st_idle |=> r.st == st_idle)
		else $error("trigger taken while blocked");
	count_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		accept && r.count == count_top |=> r.count == 31'h00000000)
		else $error("counter did not wrap");
	count_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!accept && !clear_cmd |=> r.count == $past(r.count))
		else $error("counter moved without trigger");
	count_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		clear_cmd && !accept |=> r.count == 31'h00000000)
		else $error("counter not cleared");
	abort_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		abort_cmd && r.st inside {st_expose, st_gap, st_lag, st_measure} |=> !r.expo)
		else $error("abort ignored");
	filter_reject_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_qualify && !trig_now |=> r.st == st_idle && !r.expo)
		else $error("short pulse not rejected");
	mult_legal_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$onehot(r.mult))
		else $error("illegal multiplier");
	length_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.burst_length <= burst_length_max)
		else $error("burst length out of range");
	alternate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_expose && next_r.st == st_gap && r.style == two_time_alternate
		|=> r.phase != $past(r.phase))
		else $error("phase did not alternate");

	// Sequencer, time base and bus guards
	idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_idle |-> !r.expo)
		else $error("exposure while idle");
	filter_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_qualify |-> !r.expo)
		else $error("exposure before width accepted");
	blocked_accept_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.block && r.st == st_idle |-> !accept)
		else $error("blocked trigger counted");
	lag_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_lag && r.timer < 28'(r.lag_us) |=> !r.expo)
		else $error("exposure before lag elapsed");
	lag_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		accept |=> r.st == st_lag && !r.expo)
		else $error("accepted trigger skipped the lag");
	tick_align_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.tick |-> r.div == 7'h00)
		else $error("tick out of step with divider");
	gap_resume_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_gap && !abort_cmd |=> r.st == st_expose && r.expo)
		else $error("burst did not resume after gap");
	measure_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_measure && trig_now && !abort_cmd |=> r.expo)
		else $error("width exposure ended early");
	second_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.st == st_expose && r.phase |-> second_exposure)
		else $error("second exposure flag missing");
	bus_answer_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

endmodule

// ==== burst_trigger_pkg.sv ====
// Constants and types shared by the burst trigger sequencer
package burst_trigger_pkg;

	// ----------------------------------------------------------------
	// Register map (word addresses, byte address = 4 x word)
	// ----------------------------------------------------------------
	localparam logic [3:0] reg_control = 4'h0; // Styles, gates, commands
	localparam logic [3:0] reg_burst_length = 4'h1; // Exposure count, 0 = endless
	localparam logic [3:0] reg_shutter_us = 4'h2; // First shutter time
	localparam logic [3:0] reg_second_shutter_us = 4'h3; // Second shutter time
	localparam logic [3:0] reg_trig_lag_us = 4'h4; // Trigger lag
	localparam logic [3:0] reg_width_filter_min_us = 4'h5; // Minimum accepted width
	localparam logic [3:0] reg_accepted_count = 4'h6; // Accepted trigger count
	localparam logic [3:0] reg_status = 4'h7; // Sequencer state

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int ctl_style_lo = 0; // burst_style, 2 bits
	localparam int ctl_policy = 2; // burst_end_policy
	localparam int ctl_source = 3; // shutter_source
	localparam int ctl_origin_lo = 4; // trig_origin, 3 bits
	localparam int ctl_block = 7; // trig_block
	localparam int ctl_filter = 8; // width_filter_on
	localparam int ctl_mult_lo = 9; // second_width_multiplier, 5 bits
	localparam int ctl_abort = 16; // burst_abort command, write 1
	localparam int ctl_clear = 17; // accepted_count_clear command, write 1
	localparam int ctl_soft = 18; // Software trigger command, write 1

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] style_off = 2'h0;
	localparam logic [1:0] one_time_repeat = 2'h1;
	localparam logic [1:0] two_time_alternate = 2'h2;
	localparam logic count_limited = 1'h0;
	localparam logic while_asserted = 1'h1;
	localparam logic edge_timed = 1'h0;
	localparam logic pulse_width_timed = 1'h1;
	localparam logic [2:0] origin_line1 = 3'h0;
	localparam logic [2:0] origin_line2 = 3'h1;
	localparam logic [2:0] origin_soft = 3'h4;
	localparam logic [15:0] burst_length_rst = 16'h0001;
	localparam logic [15:0] burst_length_max = 16'hfffd;
	localparam logic [22:0] shutter_rst = 23'h002580;
	localparam logic [22:0] second_shutter_rst = 23'h01481e;
	localparam logic [22:0] shutter_min = 23'h000001;
	localparam logic [22:0] shutter_max = 23'h5b8d80;
	localparam logic [22:0] lag_rst = 23'h000000;
	localparam logic [22:0] lag_max = 23'h3d0900;
	localparam logic [22:0] filter_min_rst = 23'h000001;
	localparam logic [22:0] filter_min_max = 23'h1e8480;
	localparam logic [30:0] count_top = 31'h7fffffff;
	localparam logic [4:0] mult_rst = 5'h01;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	localparam int clk_mhz = 100; // System clock rate
	localparam int tick_us = 1; // Tick period in microseconds
	localparam int tick_cycles = tick_us * clk_mhz; // Cycles per tick
	localparam logic [6:0] tick_last = 7'(tick_cycles - 1);

	// Sequencer states
	typedef enum logic [2:0] {
		st_idle, st_qualify, st_lag, st_measure, st_expose, st_gap
	} seq_state_t;

endpackage

// ==== trig_source.sv ====
// Model of the external trigger source that drives both trigger lines
`timescale 1ns/10ps
module trig_source (
	input wire logic sys_clk,
	output logic trig_line1,
	output logic trig_line2
);
	// ------------------------------------------------------------
	// Pulse generator
	// ------------------------------------------------------------
	// Lines rest low between pulses, as behind a pull-down
	initial begin
		trig_line1 = 1'b0;
		trig_line2 = 1'b0;
	end

	// Raise one line, active high, for a number of clock cycles
	task automatic pulse(input int line, input int cycles);
		@(posedge sys_clk);
		if (line == 1) begin
			trig_line1 <= 1'b1;
		end else begin
			trig_line2 <= 1'b1;
		end
		repeat (cycles) @(posedge sys_clk);
		trig_line1 <= 1'b0;
		trig_line2 <= 1'b0;
	endtask
endmodule

// ==== burst_trigger_sequencer_tb_top.sv ====
// Self-checking bench for the burst trigger sequencer
`timescale 1ns/10ps
module burst_trigger_sequencer_tb_top
	import burst_trigger_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and monitor state
	// ------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] be = 4'hf; // Byte enables, full word normally
	logic [31:0] avs_readdata;
	logic [31:0] rd; // Last read data
	logic [31:0] c0; // Saved trigger count
	logic avs_waitrequest;
	logic trig_line1;
	logic trig_line2;
	logic exposure;
	logic second_exposure;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0; // Cycle counter
	int n_exp = 0; // Exposures started
	int n_sec = 0; // Second-phase exposures started
	int cur = 0; // Length of exposure in progress
	int len = 0; // Length of last exposure
	int plen = 0; // Length of the one before
	int t_rise = 0; // Cycle of last exposure start
	int t0 = 0; // Cycle of last trigger
	int e0 = 0;
	int s0 = 0;
	int em = 1;
	bit ex_d = 1'b0;
	bit sx_d = 1'b0;

	always #5 sys_clk = ~sys_clk;

	burst_trigger_sequencer dut (
		.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.trig_line1(trig_line1), .trig_line2(trig_line2), .exposure(exposure),
		.second_exposure(second_exposure)
	);

	trig_source src (.sys_clk(sys_clk), .trig_line1(trig_line1), .trig_line2(trig_line2));

	// Measure count, start and length of exposures
	always @(posedge sys_clk) begin
		cyc++;
		if (exposure === 1'b1 && !ex_d) begin
			n_exp++;
			t_rise = cyc;
			cur = 1;
		end else if (exposure === 1'b1) begin
			cur++;
		end else if (ex_d) begin
			plen = len;
			len = cur;
		end
		if (second_exposure === 1'b1 && !sx_d) n_sec++;
		ex_d = (exposure === 1'b1);
		sx_d = (second_exposure === 1'b1);
	end

	// ------------------------------------------------------------
	// Bus, trigger and compare tasks
	// ------------------------------------------------------------
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic rw, input logic [3:0] w, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= {w, 2'b00};
		avs_writedata <= d;
		if (rw) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 100);
		rd = avs_readdata;
		if (k >= 100) begin
			n_errors++;
			$display("unexpected waitrequest: expected 0, seen %0b", avs_waitrequest);
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [3:0] w, input logic [31:0] d);
		bus(1'b1, w, d);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %0d, seen %0d", nm, e, g);
		end
	endtask

	// Cycle figures compared within a tolerance for tick alignment
	task automatic near(input string nm, input int e, input int g, input int tol);
		n_checks++;
		if (g < e - tol || g > e + tol) begin
			n_errors++;
			$display("unexpected %s: expected %0d, seen %0d", nm, e, g);
		end
	endtask

	task automatic rdc(input logic [3:0] w, input logic [31:0] e, input string nm);
		bus(1'b0, w, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic exps(input logic [31:0] e);
		chk("exposures", e, 32'(n_exp - e0));
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Return on the edge after a microsecond tick, so widths span whole ticks
	task automatic tick_sync;
		do begin
			@(posedge sys_clk);
		end while (dut.r.tick !== 1'b1);
	endtask

	// Trigger pulse on a line, remembering the start point
	task automatic fire(input int line, input int w);
		t0 = cyc;
		e0 = n_exp;
		s0 = n_sec;
		src.pulse(line, w);
	endtask

	function automatic logic [31:0] cw(input logic [1:0] st, input logic pol,
		input logic sh, input logic [2:0] org, input logic [4:0] m);
		logic [31:0] c;
		c = 32'h0;
		c[ctl_style_lo +: 2] = st;
		c[ctl_policy] = pol;
		c[ctl_source] = sh;
		c[ctl_origin_lo +: 3] = org;
		c[ctl_mult_lo +: 5] = m;
		return c;
	endfunction

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog well past the expected run length
	initial begin
		wt(90000);
		$display("unexpected run length: expected under 90000 cycles, seen more");
		n_errors++;
		results;
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		wt(12);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rdc(reg_burst_length, 32'd1, "burst_length");
		rdc(reg_second_shutter_us, 32'd83998, "second");
		rdc(reg_trig_lag_us, 32'd0, "lag");
		rdc(reg_width_filter_min_us, 32'd1, "filter_min");
		rdc(reg_accepted_count, 32'd0, "count");
		rdc(4'h8, 32'd0, "unmapped");
		wr(reg_burst_length, 32'd65534);
		rdc(reg_burst_length, 32'd1, "burst_length");
		wr(reg_burst_length, 32'd65533);
		rdc(reg_burst_length, 32'd65533, "burst_length");
		wr(reg_second_shutter_us, 32'd6000001);
		rdc(reg_second_shutter_us, 32'd83998, "second");
		be <= 4'h3;
		wr(reg_shutter_us, 32'd2);
		be <= 4'hf;
		rdc(reg_shutter_us, 32'd9600, "shutter");
		// Count-limited repeat of one shutter time
		wr(reg_shutter_us, 32'd2);
		wr(reg_second_shutter_us, 32'd4);
		wr(reg_burst_length, 32'd3);
		wr(reg_control, cw(one_time_repeat, count_limited, edge_timed, origin_line1, 5'h01));
		fire(1, 50);
		wt(1000);
		exps(32'd3);
		near("shutter len", 200, len, 110);
		rdc(reg_accepted_count, 32'd1, "count");
		// Alternate first and second shutter
		wr(reg_burst_length, 32'd4);
		wr(reg_control, cw(two_time_alternate, count_limited, edge_timed, origin_line1, 5'h01));
		fire(1, 50);
		wt(1600);
		exps(32'd4);
		chk("seconds", 32'd2, 32'(n_sec - s0));
		near("second len", 400, len, 110);
		near("first len", 200, plen, 110);
		// Blocked trigger
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, 3'h0, 5'h01) | (32'h1 << ctl_block));
		fire(1, 50);
		wt(600);
		exps(32'd0);
		rdc(reg_accepted_count, 32'd2, "count");
		// Width alternate for each multiplier, the last code illegal
		wr(reg_burst_length, 32'd2);
		for (int i = 0; i < 6; i++) begin
			em = (i == 5) ? 16 : (1 << i);
			wr(reg_control, cw(two_time_alternate, while_asserted, pulse_width_timed,
				origin_line1, (i == 5) ? 5'h03 : 5'(em)));
			tick_sync;
			fire(1, 300);
			wt(300 * em + 900);
			exps(32'd2);
			near("width len", 300, plen, 110);
			near("multiplied len", em * plen, len, 110 * em);
		end
		// While asserted under edge timing
		wr(reg_control, cw(one_time_repeat, while_asserted, edge_timed, origin_line1, 5'h01));
		wr(reg_burst_length, 32'd0);
		fire(1, 1000);
		wt(500);
		near("held exposures", 5, n_exp - e0, 1);
		chk("exposure", 32'h0, {31'h0, exposure});
		wr(reg_burst_length, 32'd2);
		fire(1, 2000);
		wt(200);
		exps(32'd2);
		// Abort of an endless burst
		wr(reg_control, cw(one_time_repeat, count_limited, edge_timed, origin_line1, 5'h01));
		wr(reg_burst_length, 32'd0);
		fire(1, 50);
		wt(1000);
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, 3'h0, 5'h01) | (32'h1 << ctl_abort));
		wt(300);
		e0 = n_exp;
		wt(1000);
		exps(32'd0);
		// Trigger lag
		wr(reg_burst_length, 32'd1);
		wr(reg_trig_lag_us, 32'd5);
		fire(1, 50);
		wt(900);
		near("lag latency", 500, t_rise - t0, 110);
		// Width filter
		wr(reg_trig_lag_us, 32'd0);
		wr(reg_width_filter_min_us, 32'd4);
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, 3'h0, 5'h01) | (32'h1 << ctl_filter));
		bus(1'b0, reg_accepted_count, 32'h0);
		c0 = rd;
		fire(1, 200);
		wt(800);
		exps(32'd0);
		rdc(reg_accepted_count, c0, "count");
		fire(1, 600);
		wt(600);
		near("filter latency", 400, t_rise - t0, 110);
		rdc(reg_accepted_count, c0 + 32'd1, "count");
		// Trigger origins
		wr(reg_control, cw(one_time_repeat, count_limited, edge_timed, origin_line2, 5'h01));
		fire(1, 50);
		wt(500);
		exps(32'd0);
		fire(2, 50);
		wt(500);
		exps(32'd1);
		e0 = n_exp;
		// Select the software origin first, then issue the command
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, origin_soft, 5'h01));
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, origin_soft, 5'h01) | (32'h1 << ctl_soft));
		wt(500);
		exps(32'd1);
		// Counter clear
		wr(reg_control, cw(one_time_repeat, 1'b0, 1'b0, 3'h0, 5'h01) | (32'h1 << ctl_clear));
		rdc(reg_accepted_count, 32'd0, "count");
		// Style off: one exposure per trigger whatever the burst length
		wr(reg_burst_length, 32'd3);
		wr(reg_control, cw(style_off, count_limited, edge_timed, origin_line1, 5'h04));
		rdc(reg_control, cw(style_off, count_limited, edge_timed, origin_line1, 5'h04),
			"control");
		fire(1, 50);
		wt(600);
		exps(32'd1);
		rdc(reg_accepted_count, 32'd1, "count");
		rdc(reg_status, 32'd0, "status");
		results;
	end
endmodule
